// ==== pkg/dac_ctrl_regs.svh ====
`ifndef DAC_CTRL_REGS_SVH
`define DAC_CTRL_REGS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define NUM_CH        40
`define NUM_GROUPS    5
`define CODE_W        14

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_PD_BIT      0
`define CTRL_TSD_EN_BIT  1
`define CTRL_TSD_FLAG_BIT 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LEVEL_RST     14'h2000
`define GAIN_RST      14'h3FFF
`define OFFSET_RST    14'h2000
`define CORR_RST      14'h2000
`define OFFSET_ZERO   17'sh0_2000
`define CODE_MAX      17'sh0_3FFF

// ----------------------------------------
// Timing, 20 MHz clock
// ----------------------------------------
`define CLK_NS        50
`define STAGE1_NS     600
`define STAGE2_NS     600
`define STAGE3_NS     300
`define SEL_BUSY_NS   500
`define STAGE1_CYC    ((`STAGE1_NS) / (`CLK_NS))
`define STAGE2_CYC    ((`STAGE2_NS) / (`CLK_NS))
`define STAGE3_CYC    ((`STAGE3_NS) / (`CLK_NS))
`define SEL_BUSY_CYC  ((`SEL_BUSY_NS) / (`CLK_NS))

`endif

// ==== pkg/dac_ctrl_pkg.sv ====
`include "dac_ctrl_regs.svh"

package dac_ctrl_pkg;

  typedef enum logic [2:0] {
    WR_LEVEL_A = 3'h0,
    WR_LEVEL_B = 3'h1,
    WR_GAIN    = 3'h2,
    WR_OFFSET  = 3'h3,
    WR_SELECT  = 3'h4,
    WR_CTRL    = 3'h5
  } wr_kind_t;

  typedef enum logic [2:0] {
    AM_SINGLE   = 3'h0,
    AM_GROUP    = 3'h1,
    AM_SAME_0_4 = 3'h2,
    AM_SAME_1_4 = 3'h3,
    AM_ALL      = 3'h4
  } addr_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_STAGE1 = 4'b0010,
    ST_STAGE2 = 4'b0100,
    ST_STAGE3 = 4'b1000
  } calc_state_t;

  typedef struct packed {
    logic                 valid;
    wr_kind_t             kind;
    addr_mode_t           mode;
    logic [2:0]           group;
    logic [2:0]           chan;
    logic [`CODE_W-1:0]   data;
  } wr_req_t;

  typedef struct packed {
    logic load_strobe_n;
    logic busy_line_n;
    logic output_clear_n;
    logic over_temp;
  } pin_in_t;

endpackage

// ==== rtl/sync_2ff.sv ====
`timescale 1ns/1ps

module sync_2ff #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  input  wire logic [W-1:0] rst_val_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_r;

  // ----------------------------------------
  // Two flops, first read only by second
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= '0;
      q_out  <= '0;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end

endmodule

// ==== rtl/level_calc.sv ====
`timescale 1ns/1ps
`include "dac_ctrl_regs.svh"

module level_calc (
  input  wire logic [13:0] level_in,
  input  wire logic [13:0] gain_in,
  input  wire logic [13:0] offset_in,
  output logic      [13:0] corrected_out
);

  logic        [28:0] prod;
  logic signed [16:0] sum;

  // ----------------------------------------
  // Shared multiplier and clamp
  // ----------------------------------------
  always_comb begin
    prod = 29'(level_in) * 29'({1'b0, gain_in} + 15'h0001);
    sum  = $signed({2'b00, prod[28:14]}) + $signed({3'b000, offset_in}) - `OFFSET_ZERO;
    if (sum < 17'sh0_0000) begin
      corrected_out = 14'h0000;
    end else if (sum > `CODE_MAX) begin
      corrected_out = 14'h3FFF;
    end else begin
      corrected_out = sum[13:0];
    end
  end

endmodule

// ==== rtl/dac_update_ctrl.sv ====
// What this block does
// - Level, gain or offset write starts recalculation; busy held low throughout.
// - Writes accepted while busy low, but no DAC register transfer then.
// - Open-drain shared busy; load waits until whole line is released.
// - Load strobe falling during busy is stored, done right after busy rises.
// - Strobe held low: update after every busy rising edge.
// - Toggle select write holds busy low about 500 ns.
// - Writes target 1, 4, 5, 8 or 40 channels.
// - One multiplier, channels in sequence; busy (n+1)*600+300 ns unless a write in stage 2 or 3 restarts stage 1.
// - Load updates only channels with corrected level written since last load.
// - Updated DAC register takes corrected A or B per select bit.
// - Power-down bit 0 turns DACs off, outputs to group ground.
// - Power-down keeps registers; clearing restores previous output.
// - Thermal enable bit 1 plus over-temperature forces power-down state.
// - Entering thermal shutdown sets status bit 4.
// - Thermal shutdown latched until enable bit is cleared.
// - Two corrected levels per channel, from input level A and B.
// - Five 8-bit select registers; bit n of k drives channel 8k+n.
// - Select bit 0 chooses corrected A, 1 chooses corrected B.
// - Stages of 600, 600, 300 ns; first stage repeats per channel.
// - Clear input low grounds outputs and ignores load strobes.
`timescale 1ns/1ps
`include "dac_ctrl_regs.svh"

module dac_update_ctrl (
  input  wire logic                                  clk_in,
  input  wire logic                                  rst_in,
  input  wire dac_ctrl_pkg::wr_req_t                 wr_in,
  input  wire dac_ctrl_pkg::pin_in_t                 pins_in,
  output logic                                       busy_n_out,
  output logic                                       busy_oe_n_out,
  output logic [`NUM_CH-1:0][`CODE_W-1:0]            dac_code_out,
  output logic                                       outputs_ground_out,
  output logic                                       dac_off_out,
  output logic                                       dac_update_out,
  output logic [7:0]                                 ctrl_status_out,
  output logic [`NUM_GROUPS-1:0][7:0]                toggle_select_out
);

  localparam logic [3:0] STAGE1_LAST = 4'(`STAGE1_CYC - 1);
  localparam logic [3:0] STAGE1_HALF = 4'(`STAGE1_CYC / 2 - 1);
  localparam logic [3:0] STAGE2_LAST = 4'(`STAGE2_CYC - 1);
  localparam logic [3:0] STAGE3_LAST = 4'(`STAGE3_CYC - 1);
  localparam logic [3:0] SEL_CYC     = 4'(`SEL_BUSY_CYC);

  typedef struct packed {
    dac_ctrl_pkg::calc_state_t          st;
    logic [3:0]                         cnt;
    logic [3:0]                         sel_cnt;
    logic [`NUM_CH-1:0]                 pend_a;
    logic [`NUM_CH-1:0]                 pend_b;
    logic [`NUM_CH-1:0]                 dirty;
    logic [`NUM_CH-1:0]                 sel;
    logic [5:0]                         cur;
    logic                               cur_b;
    logic                               load_pend;
    logic                               line_q;
    logic                               ld_q;
    logic                               pd;
    logic                               tsd_en;
    logic                               tsd;
    logic                               gnd;
    logic                               upd;
    logic [`NUM_CH-1:0][`CODE_W-1:0]    in_a;
    logic [`NUM_CH-1:0][`CODE_W-1:0]    in_b;
    logic [`NUM_CH-1:0][`CODE_W-1:0]    gain;
    logic [`NUM_CH-1:0][`CODE_W-1:0]    offs;
    logic [`NUM_CH-1:0][`CODE_W-1:0]    corr_a;
    logic [`NUM_CH-1:0][`CODE_W-1:0]    corr_b;
    logic [`NUM_CH-1:0][`CODE_W-1:0]    dac;
  } state_t;

  localparam state_t RST_STATE = '{
    st:        dac_ctrl_pkg::ST_IDLE,
    cnt:       4'h0,
    sel_cnt:   4'h0,
    pend_a:    '0,
    pend_b:    '0,
    dirty:     '0,
    sel:       '0,
    cur:       6'h00,
    cur_b:     1'b0,
    load_pend: 1'b0,
    line_q:    1'b1,
    ld_q:      1'b1,
    pd:        1'b0,
    tsd_en:    1'b0,
    tsd:       1'b0,
    gnd:       1'b1,
    upd:       1'b0,
    in_a:      {`NUM_CH{`LEVEL_RST}},
    in_b:      {`NUM_CH{`LEVEL_RST}},
    gain:      {`NUM_CH{`GAIN_RST}},
    offs:      {`NUM_CH{`OFFSET_RST}},
    corr_a:    {`NUM_CH{`CORR_RST}},
    corr_b:    {`NUM_CH{`CORR_RST}},
    dac:       {`NUM_CH{`CORR_RST}}
  };

  state_t                  s_r;
  state_t                  s_nxt;
  dac_ctrl_pkg::pin_in_t   pin_s;
  logic [`NUM_CH-1:0]      tgt;
  logic [`NUM_CH-1:0]      pend_any;
  logic [5:0]              pick;
  logic                    own_busy;
  logic                    ld_fall;
  logic                    line_rise;
  logic [13:0]             calc_y;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  sync_2ff #(
    .W (4)
  ) u_sync (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .d_in       (pins_in),
    .rst_val_in (4'h0),
    .q_out      (pin_s)
  );

  // ----------------------------------------
  // Shared multiplier
  // ----------------------------------------
  level_calc u_calc (
    .level_in      (s_r.cur_b ? s_r.in_b[s_r.cur] : s_r.in_a[s_r.cur]),
    .gain_in       (s_r.gain[s_r.cur]),
    .offset_in     (s_r.offs[s_r.cur]),
    .corrected_out (calc_y)
  );

  // ----------------------------------------
  // Target channels of a write
  // ----------------------------------------
  function automatic logic [`NUM_CH-1:0] target_mask(input dac_ctrl_pkg::wr_req_t w);
    logic [`NUM_CH-1:0] m;
    m = '0;
    case (w.mode)
      dac_ctrl_pkg::AM_SINGLE: begin
        if (w.group < 3'd5) m[{w.group, w.chan}] = 1'b1;
      end
      dac_ctrl_pkg::AM_GROUP: begin
        if (w.group < 3'd5) m[{w.group, 3'b000} +: 8] = 8'hFF;
      end
      dac_ctrl_pkg::AM_SAME_0_4: begin
        for (int g = 0; g < `NUM_GROUPS; g++) m[g * 8 + int'(w.chan)] = 1'b1;
      end
      dac_ctrl_pkg::AM_SAME_1_4: begin
        for (int g = 1; g < `NUM_GROUPS; g++) m[g * 8 + int'(w.chan)] = 1'b1;
      end
      dac_ctrl_pkg::AM_ALL: begin
        m = '1;
      end
      default: begin
        m = '0;
      end
    endcase
    return m;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt     = s_r;
    s_nxt.upd = 1'b0;
    tgt       = target_mask(wr_in);
    pend_any  = s_r.pend_a | s_r.pend_b;
    pick      = 6'h00;
    for (int i = `NUM_CH - 1; i >= 0; i--) begin
      if (pend_any[i]) pick = 6'(i);
    end
    own_busy  = (s_r.st != dac_ctrl_pkg::ST_IDLE) || (s_r.sel_cnt != 4'h0);
    ld_fall   = s_r.ld_q && !pin_s.load_strobe_n;
    line_rise = !s_r.line_q && pin_s.busy_line_n;
    s_nxt.ld_q   = pin_s.load_strobe_n;
    s_nxt.line_q = pin_s.busy_line_n;

    // Load requests; strobes ignored while clear is low
    if (pin_s.output_clear_n) begin
      if (ld_fall) s_nxt.load_pend = 1'b1;
      if (line_rise && !pin_s.load_strobe_n) s_nxt.load_pend = 1'b1;
    end

    // Transfer only once the whole wired line is high
    if (s_nxt.load_pend && pin_s.busy_line_n && !own_busy && pin_s.output_clear_n) begin
      for (int i = 0; i < `NUM_CH; i++) begin
        if (s_r.dirty[i]) begin
          s_nxt.dac[i] = s_r.sel[i] ? s_r.corr_b[i] : s_r.corr_a[i];
        end
      end
      s_nxt.dirty     = '0;
      s_nxt.load_pend = 1'b0;
      s_nxt.upd       = 1'b1;
    end

    // Calculation sequencer
    s_nxt.cnt = s_r.cnt + 4'h1;
    case (s_r.st)
      dac_ctrl_pkg::ST_IDLE: begin
        s_nxt.cnt = 4'h0;
        if (pend_any != '0) begin
          s_nxt.st    = dac_ctrl_pkg::ST_STAGE1;
          s_nxt.cur   = pick;
          s_nxt.cur_b = !s_r.pend_a[pick];
        end
      end
      dac_ctrl_pkg::ST_STAGE1: begin
        // A and B of one channel share its slot, so busy stays within bound
        if (s_r.cnt == STAGE1_HALF && !s_r.cur_b && s_r.pend_b[s_r.cur]) begin
          s_nxt.corr_a[s_r.cur] = calc_y;
          s_nxt.pend_a[s_r.cur] = 1'b0;
          s_nxt.dirty[s_r.cur]  = 1'b1;
          s_nxt.cur_b           = 1'b1;
        end
        if (s_r.cnt == STAGE1_LAST) begin
          s_nxt.cnt = 4'h0;
          if (s_r.cur_b) begin
            s_nxt.corr_b[s_r.cur] = calc_y;
            s_nxt.pend_b[s_r.cur] = 1'b0;
          end else begin
            s_nxt.corr_a[s_r.cur] = calc_y;
            s_nxt.pend_a[s_r.cur] = 1'b0;
          end
          s_nxt.dirty[s_r.cur] = 1'b1;
          if ((s_nxt.pend_a | s_nxt.pend_b) != '0) begin
            for (int i = `NUM_CH - 1; i >= 0; i--) begin
              if (s_nxt.pend_a[i] || s_nxt.pend_b[i]) s_nxt.cur = 6'(i);
            end
            s_nxt.cur_b = !s_nxt.pend_a[s_nxt.cur];
          end else begin
            s_nxt.st = dac_ctrl_pkg::ST_STAGE2;
          end
        end
      end
      dac_ctrl_pkg::ST_STAGE2: begin
        if (s_r.cnt == STAGE2_LAST) begin
          s_nxt.cnt = 4'h0;
          s_nxt.st  = dac_ctrl_pkg::ST_STAGE3;
        end
      end
      dac_ctrl_pkg::ST_STAGE3: begin
        if (s_r.cnt == STAGE3_LAST) begin
          s_nxt.cnt = 4'h0;
          s_nxt.st  = dac_ctrl_pkg::ST_IDLE;
          // Late writes restart the per-channel stage
          if (pend_any != '0) begin
            s_nxt.st    = dac_ctrl_pkg::ST_STAGE1;
            s_nxt.cur   = pick;
            s_nxt.cur_b = !s_r.pend_a[pick];
          end
        end
      end
      default: begin
        s_nxt.st  = dac_ctrl_pkg::ST_IDLE;
        s_nxt.cnt = 4'h0;
      end
    endcase

    if (s_r.sel_cnt != 4'h0) s_nxt.sel_cnt = s_r.sel_cnt - 4'h1;

    // Host writes; a new request wins over a sequencer clear
    if (wr_in.valid) begin
      case (wr_in.kind)
        dac_ctrl_pkg::WR_LEVEL_A: begin
          for (int i = 0; i < `NUM_CH; i++) begin
            if (tgt[i]) s_nxt.in_a[i] = wr_in.data;
          end
          s_nxt.pend_a = s_nxt.pend_a | tgt;
        end
        dac_ctrl_pkg::WR_LEVEL_B: begin
          for (int i = 0; i < `NUM_CH; i++) begin
            if (tgt[i]) s_nxt.in_b[i] = wr_in.data;
          end
          s_nxt.pend_b = s_nxt.pend_b | tgt;
        end
        dac_ctrl_pkg::WR_GAIN: begin
          for (int i = 0; i < `NUM_CH; i++) begin
            if (tgt[i]) s_nxt.gain[i] = wr_in.data;
          end
          s_nxt.pend_a = s_nxt.pend_a | tgt;
          s_nxt.pend_b = s_nxt.pend_b | tgt;
        end
        dac_ctrl_pkg::WR_OFFSET: begin
          for (int i = 0; i < `NUM_CH; i++) begin
            if (tgt[i]) s_nxt.offs[i] = wr_in.data;
          end
          s_nxt.pend_a = s_nxt.pend_a | tgt;
          s_nxt.pend_b = s_nxt.pend_b | tgt;
        end
        dac_ctrl_pkg::WR_SELECT: begin
          if (wr_in.group < 3'd5) begin
            s_nxt.sel[{wr_in.group, 3'b000} +: 8] = wr_in.data[7:0];
          end
          s_nxt.sel_cnt = SEL_CYC;
        end
        dac_ctrl_pkg::WR_CTRL: begin
          s_nxt.pd     = wr_in.data[`CTRL_PD_BIT];
          s_nxt.tsd_en = wr_in.data[`CTRL_TSD_EN_BIT];
        end
        default: begin
          s_nxt.pd = s_r.pd;
        end
      endcase
    end

    // Thermal shutdown latch
    if (!s_nxt.tsd_en) begin
      s_nxt.tsd = 1'b0;
    end else if (pin_s.over_temp) begin
      s_nxt.tsd = 1'b1;
    end

    // Grounding never touches stored codes, so release restores levels
    s_nxt.gnd = s_nxt.pd || s_nxt.tsd || !pin_s.output_clear_n;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= RST_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign busy_n_out         = 1'b0;
  assign busy_oe_n_out      = !own_busy;
  assign dac_code_out       = s_r.dac;
  assign outputs_ground_out = s_r.gnd;
  assign dac_off_out        = s_r.pd || s_r.tsd;
  assign dac_update_out     = s_r.upd;
  assign ctrl_status_out    = {3'b000, s_r.tsd, 2'b00, s_r.tsd_en, s_r.pd};
  assign toggle_select_out  = s_r.sel;

endmodule

// ==== tb/dac_update_ctrl_sva.sv ====
`timescale 1ns/1ps
`include "dac_ctrl_regs.svh"

module dac_update_ctrl_sva (
  input wire logic                            clk_in,
  input wire logic                            rst_in,
  input wire dac_ctrl_pkg::wr_req_t           wr_in,
  input wire dac_ctrl_pkg::pin_in_t           pins_in,
  input wire logic                            busy_n_out,
  input wire logic                            busy_oe_n_out,
  input wire logic [`NUM_CH-1:0][`CODE_W-1:0] dac_code_out,
  input wire logic                            outputs_ground_out,
  input wire logic                            dac_off_out,
  input wire logic                            dac_update_out,
  input wire logic [7:0]                      ctrl_status_out,
  input wire logic [`NUM_GROUPS-1:0][7:0]     toggle_select_out
);
  // ----
  // Helpers
  // ----
  wire en_clr = wr_in.valid && wr_in.kind == dac_ctrl_pkg::WR_CTRL && !wr_in.data[1];
  wire sel_wr = wr_in.valid && wr_in.kind == dac_ctrl_pkg::WR_SELECT;
  wire lvl_go = busy_oe_n_out && wr_in.valid && wr_in.kind == dac_ctrl_pkg::WR_LEVEL_A
                && wr_in.mode == dac_ctrl_pkg::AM_SINGLE && wr_in.group <= 3'h4;

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // ----
  // Checks
  // ----
  lvl_busy_a: assert property (lvl_go |=> ##1 !busy_oe_n_out ##29 !busy_oe_n_out)
    else $error("level write busy too short");
  sel_busy_a: assert property (busy_oe_n_out && sel_wr |=> !busy_oe_n_out ##9 !busy_oe_n_out)
    else $error("select write busy too short");
  no_load_busy_a: assert property (dac_update_out |-> $past(busy_oe_n_out))
    else $error("transfer while own busy");
  code_hold_a: assert property ($changed(dac_code_out) |-> dac_update_out)
    else $error("dac code moved without load");
  clear_drop_a: assert property (!pins_in.output_clear_n [*5] |-> !dac_update_out)
    else $error("load during clear");
  ground_off_a: assert property (dac_off_out && $past(dac_off_out) |-> outputs_ground_out)
    else $error("dacs off but outputs not grounded");
  off_status_a: assert property (dac_off_out == (ctrl_status_out[0] || ctrl_status_out[4]))
    else $error("off state disagrees with status");
  tsd_latch_a: assert property (ctrl_status_out[4] && !en_clr |=> ctrl_status_out[4])
    else $error("thermal flag dropped");
  tsd_enter_a: assert property ((pins_in.over_temp && ctrl_status_out[1] && !en_clr) [*5]
                                |-> ctrl_status_out[4])
    else $error("thermal shutdown not entered");
  sel_store_a: assert property (sel_wr && wr_in.group <= 3'h4
    |=> toggle_select_out[$past(wr_in.group)] == $past(wr_in.data[7:0]))
    else $error("select register not written");
endmodule

bind dac_update_ctrl dac_update_ctrl_sva chk (
  .clk_in(clk_in), .rst_in(rst_in), .wr_in(wr_in), .pins_in(pins_in),
  .busy_n_out(busy_n_out), .busy_oe_n_out(busy_oe_n_out), .dac_code_out(dac_code_out),
  .outputs_ground_out(outputs_ground_out), .dac_off_out(dac_off_out),
  .dac_update_out(dac_update_out), .ctrl_status_out(ctrl_status_out),
  .toggle_select_out(toggle_select_out));

// ==== tb/busy_peer_model.sv ====
`timescale 1ns/1ps

// ----
// Peer device on the shared busy wire
// ----
module busy_peer_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       own_oe_n_in,
  input  wire logic       go_in,
  input  wire logic [7:0] len_in,
  output logic            line_n_out
);
  logic [7:0] hold_r;

  // Peer keeps the wire low until its own work ends
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) hold_r <= 8'h00;
    else if (go_in) hold_r <= len_in;
    else if (hold_r != 8'h00) hold_r <= hold_r - 8'h01;
  end

  // Pull-up wins only when no party pulls low
  assign line_n_out = own_oe_n_in && (hold_r == 8'h00);
endmodule

// ==== tb/dac_update_busy_toggle_ctrl_tb.sv ====
`timescale 1ns/1ps
`include "dac_ctrl_regs.svh"

module dac_update_busy_toggle_ctrl_tb;
  logic clk_in, rst_in, strobe_n, clear_n, hot, peer_go, line_n, busy_oe_n, ground, off, upd;
  logic busy_d;
  logic [7:0]                      peer_len, status;
  dac_ctrl_pkg::wr_req_t           wr_in;
  dac_ctrl_pkg::pin_in_t           pins;
  logic [`NUM_CH-1:0][`CODE_W-1:0] code;
  logic [`NUM_GROUPS-1:0][7:0]     sel;
  int n_mismatch, checked, n_upd, u0, cyc, bc;
  // Rows: group, same 0-4, same 1-4, all, gain, offset
  logic [2:0]  tk [6] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h3};
  logic [2:0]  tm [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h0};
  logic [2:0]  tg [6] = '{3'h3, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
  logic [2:0]  tc [6] = '{3'h0, 3'h5, 3'h6, 3'h0, 3'h1, 3'h2};
  logic [13:0] td [6] = '{14'h0100, 14'h0200, 14'h0300, 14'h0400, 14'h1fff, 14'h2100};
  logic [15:0] tn [6] = '{16'h0072, 16'h004e, 16'h0042, 16'h01f2, 16'h001e, 16'h001e};
  logic [15:0] te [6] = '{16'h0100, 16'h0200, 16'h0300, 16'h0400, 16'h0200, 16'h0500};
  logic [15:0] tf [6] = '{16'h2000, 16'h2000, 16'h2000, 16'h0400, 16'h0400, 16'h0200};
  int          tt [6] = '{24, 37, 14, 0, 1, 2};
  int          tx [6] = '{23, 6, 6, 39, 2, 1};

  assign pins = {strobe_n, line_n, clear_n, hot};

  dac_update_ctrl uut (
    .clk_in(clk_in), .rst_in(rst_in), .wr_in(wr_in), .pins_in(pins),
    .busy_n_out(busy_d), .busy_oe_n_out(busy_oe_n), .dac_code_out(code),
    .outputs_ground_out(ground), .dac_off_out(off), .dac_update_out(upd),
    .ctrl_status_out(status), .toggle_select_out(sel));

  busy_peer_model peer (
    .clk_in(clk_in), .rst_in(rst_in), .own_oe_n_in(busy_oe_n),
    .go_in(peer_go), .len_in(peer_len), .line_n_out(line_n));

  // ----
  // Tasks
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] cd(input int i);
    return {2'b00, code[i]};
  endfunction

  task automatic wr(input logic [2:0] k, input logic [2:0] m, input logic [2:0] g,
                    input logic [2:0] c, input logic [13:0] d);
    @(posedge clk_in);
    wr_in <= '{1'b1, dac_ctrl_pkg::wr_kind_t'(k), dac_ctrl_pkg::addr_mode_t'(m), g, c, d};
    @(posedge clk_in);
    wr_in.valid <= 1'b0;
  endtask

  // Bounded: a stuck busy must not hang the run
  task automatic busy_len;
    bc = 0;
    @(negedge clk_in);
    // A calculation starts one cycle after the write is taken
    if (busy_oe_n === 1'b1) @(negedge clk_in);
    while (busy_oe_n !== 1'b1 && bc < 1000) begin
      bc++;
      @(negedge clk_in);
    end
  endtask

  task automatic load;
    @(posedge clk_in);
    strobe_n <= 1'b0;
    repeat (4) @(posedge clk_in);
    strobe_n <= 1'b1;
    repeat (6) @(posedge clk_in);
  endtask

  task automatic wrap_up;
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  always @(negedge clk_in) if (upd === 1'b1) n_upd++;

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 32'h0000_1388) begin
      n_mismatch++;
      wrap_up;
    end
  end

  // ----
  // Sequence
  // ----
  initial begin
    rst_in = 1'b1; wr_in = '0; strobe_n = 1'b1; clear_n = 1'b1; hot = 1'b0;
    peer_go = 1'b0; peer_len = 8'h00; n_mismatch = 0; checked = 0; n_upd = 0; cyc = 0;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    chk(cd(10), 16'h2000);
    // Load requested during busy is held back
    wr(3'h0, 3'h0, 3'h1, 3'h2, 14'h1234);
    u0 = n_upd;
    fork busy_len; load; join
    repeat (6) @(posedge clk_in);
    chk(16'(bc), 16'h001e);
    chk({15'h0000, busy_d}, 16'h0000);
    chk(16'(n_upd - u0), 16'h0001);
    chk(cd(10), 16'h1234);
    chk(cd(11), 16'h2000);
    // Peer holds the wire; B chosen by select bit
    wr(3'h1, 3'h0, 3'h1, 3'h2, 14'h0abc);
    wr(3'h4, 3'h0, 3'h1, 3'h0, 14'h0004);
    peer_len <= 8'h50;
    peer_go <= 1'b1;
    @(posedge clk_in);
    peer_go <= 1'b0;
    u0 = n_upd;
    fork busy_len; load; join
    repeat (20) @(posedge clk_in);
    chk(16'(n_upd - u0), 16'h0000);
    chk(cd(10), 16'h1234);
    repeat (40) @(posedge clk_in);
    chk(16'(n_upd - u0), 16'h0001);
    chk(cd(10), 16'h0abc);
    chk({8'h00, sel[1]}, 16'h0004);
    // Select change alone does not reload
    wr(3'h4, 3'h0, 3'h1, 3'h0, 14'h0000);
    busy_len;
    chk(16'(bc), 16'h000a);
    load;
    chk(cd(10), 16'h0abc);
    // Addressing modes, gain and offset
    for (int i = 0; i < 6; i++) begin
      wr(tk[i], tm[i], tg[i], tc[i], td[i]);
      busy_len;
      chk(16'(bc), tn[i]);
      load;
      chk(cd(tt[i]), te[i]);
      chk(cd(tx[i]), tf[i]);
    end
    // Strobe held low
    strobe_n <= 1'b0;
    repeat (5) @(posedge clk_in);
    u0 = n_upd;
    wr(3'h0, 3'h0, 3'h0, 3'h3, 14'h0777);
    busy_len;
    repeat (6) @(posedge clk_in);
    chk(16'(n_upd - u0), 16'h0001);
    chk(cd(3), 16'h0777);
    strobe_n <= 1'b1;
    // Clear drops strobes
    clear_n <= 1'b0;
    wr(3'h0, 3'h0, 3'h0, 3'h4, 14'h0444);
    fork busy_len; load; join
    chk(cd(4), 16'h0400);
    chk({15'h0000, ground}, 16'h0001);
    clear_n <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk(cd(4), 16'h0400);
    chk({15'h0000, ground}, 16'h0000);
    load;
    chk(cd(4), 16'h0444);
    // Power-down and thermal shutdown
    wr(3'h5, 3'h0, 3'h0, 3'h0, 14'h0001);
    repeat (3) @(posedge clk_in);
    chk({14'h0000, off, ground}, 16'h0003);
    chk(cd(4), 16'h0444);
    wr(3'h5, 3'h0, 3'h0, 3'h0, 14'h0002);
    repeat (3) @(posedge clk_in);
    chk({14'h0000, off, ground}, 16'h0000);
    hot <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk({7'h00, off, status}, 16'h0112);
    hot <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk({7'h00, off, status}, 16'h0112);
    wr(3'h5, 3'h0, 3'h0, 3'h0, 14'h0000);
    repeat (3) @(posedge clk_in);
    chk({7'h00, off, status}, 16'h0000);
    wrap_up;
  end
endmodule
